/* dv/sed_chk_asserts.sv */
`timescale 1ns/1ns
module sed_chk #(
    parameter int TCE_CYC = 375000
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic hold_n_in,
    input wire logic so_out,
    input wire logic so_oe_n_out,
    input wire logic wip_out,
    input wire logic wel_out,
    input wire logic standby_out,
    input wire logic sleep_out
);
    int busy_cnt;
    int idle_cnt;
    always_ff @(posedge clock_in) begin
        if (!rstn_in || !wip_out) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end
    // idle time restarts on select low or busy, so power timers are judged from quiet
    always_ff @(posedge clock_in) begin
        if (!rstn_in || !cs_n_in || wip_out) begin
            idle_cnt <= 0;
        end else if (idle_cnt < 4000) begin
            idle_cnt <= idle_cnt + 1;
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    property p_oe_idle;
        cs_n_in |-> so_oe_n_out;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("so driven while deselected");
    property p_busy_bound;
        wip_out |-> busy_cnt <= TCE_CYC + 8;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
    property p_busy_needs_latch;
        $rose(wip_out) |-> wel_out;
    endproperty
    a_busy_needs_latch: assert property (p_busy_needs_latch) else $error("busy w/o latch");
    property p_latch_clears;
        $fell(wip_out) |-> ##[0:2] !wel_out;
    endproperty
    a_latch_clears: assert property (p_latch_clears) else $error("latch kept");
    property p_exec_at_rise;
        $rose(wip_out) |-> cs_n_in;
    endproperty
    a_exec_at_rise: assert property (p_exec_at_rise) else $error("busy inside frame");
    property p_latch_moves;
        $changed(wel_out) |-> cs_n_in || wip_out || $past(wip_out);
    endproperty
    a_latch_moves: assert property (p_latch_moves) else $error("latch moved in frame");
    property p_sleep_time;
        $rose(sleep_out) |-> idle_cnt >= 2400 && idle_cnt <= 2600;
    endproperty
    a_sleep_time: assert property (p_sleep_time) else $error("sleep entry time");
    property p_standby_time;
        idle_cnt == 2600 && !sleep_out |-> standby_out;
    endproperty
    a_standby_time: assert property (p_standby_time) else $error("standby late");
    property p_standby_cs;
        $rose(standby_out) |-> cs_n_in;
    endproperty
    a_standby_cs: assert property (p_standby_cs) else $error("standby in frame");
endmodule
bind sed_top sed_chk #(.TCE_CYC(TCE_CYC)) sed_chk_inst (.clock_in(clock_in),
    .rstn_in(rstn_in), .sck_in(sck_in), .cs_n_in(cs_n_in), .si_in(si_in),
    .hold_n_in(hold_n_in), .so_out(so_out), .so_oe_n_out(so_oe_n_out), .wip_out(wip_out),
    .wel_out(wel_out), .standby_out(standby_out), .sleep_out(sleep_out));

/* dv/sed_host_model.sv */
`timescale 1ns/1ns
module sed_host_model (
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out,
    output logic hold_n_out,
    input wire logic so_in
);
    // clock rests low between frames
    initial begin
        sck_out = 1'b0;
        si_out = 1'b0;
        hold_n_out = 1'b1;
        // select rises after time zero so the link's async clear sees a real edge
        #1;
        cs_n_out = 1'b1;
    end
    task automatic open_frame();
        #13;
        cs_n_out = 1'b0;
        #80;
    endtask
    task automatic shift(input logic [7:0] tx, input int nb, input bit pause,
                         output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < nb; i++) begin
            if (pause && i == 4) begin
                #40;
                hold_n_out = 1'b0;
                si_out = ~si_out;
                repeat (2) begin
                    #40;
                    sck_out = 1'b1;
                    #80;
                    sck_out = 1'b0;
                    #40;
                end
                hold_n_out = 1'b1;
                #40;
            end
            si_out = tx[7 - i];
            #80;
            sck_out = 1'b1;
            rx = {rx[6:0], so_in};
            #80;
            sck_out = 1'b0;
        end
    endtask
    task automatic close_frame();
        #80;
        cs_n_out = 1'b1;
        si_out = ~si_out;
        #400;
    endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ns
`include "sed_cfg.svh"
module tb_top;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic sck, cs_n, si, hold_n, so, so_oe_n, wip, wel, standby, sleep;
    int err_count = 0;
    int compares = 0;
    bit pause_on = 1'b0;
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    always #20 clock_in = ~clock_in;
    // short busy counts keep the run small; erase counts still exceed their byte counts
    sed_top #(.TWC_L_CYC(300), .TWC_S_CYC(300), .TSE_CYC(16400), .TCE_CYC(65540),
        .SIG_BYTE(8'h3c)) sed_top_inst (.clock_in(clock_in), .rstn_in(rstn_in),
        .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .hold_n_in(hold_n), .so_out(so),
        .so_oe_n_out(so_oe_n), .wip_out(wip), .wel_out(wel), .standby_out(standby),
        .sleep_out(sleep));
    sed_host_model sed_host_model_inst (.sck_out(sck), .cs_n_out(cs_n), .si_out(si),
        .hold_n_out(hold_n), .so_in(so));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic frame(input int last_bits);
        logic [7:0] r;
        rxq = {};
        sed_host_model_inst.open_frame();
        foreach (txq[i]) begin
            sed_host_model_inst.shift(txq[i], (i == txq.size() - 1) ? last_bits : 8,
                pause_on && i == 1, r);
            rxq.push_back(r);
        end
        sed_host_model_inst.close_frame();
    endtask
    task automatic cmd(input logic [7:0] op);
        txq = '{op};
        frame(8);
    endtask
    task automatic wait_for(input int sel, input logic val, input int lim);
        logic f;
        for (int n = 0; n <= lim; n++) begin
            @(posedge clock_in);
            f = (sel == 0) ? wip : (sel == 1) ? standby : sleep;
            if (f === val) return;
        end
        chk("wait limit", 8'h01, 8'h00);
        test_done();
    endtask
    task automatic status(input logic [7:0] exp);
        txq = '{`SED_OP_STAT_RD, 8'h00};
        frame(8);
        chk("status", exp, rxq[1]);
    endtask
    task automatic erase(input logic [7:0] op, input logic [15:0] a);
        cmd(`SED_OP_SET_LATCH);
        txq = '{op, a[15:8], a[7:0]};
        frame(8);
        wait_for(0, 1'b0, 70000);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d[$]);
        cmd(`SED_OP_SET_LATCH);
        txq = '{`SED_OP_WRITE, a[15:8], a[7:0]};
        txq = {txq, d};
        frame(8);
        wait_for(0, 1'b0, 1000);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e[$]);
        txq = '{`SED_OP_READ, a[15:8], a[7:0]};
        txq = {txq, e};
        frame(8);
        foreach (e[i]) begin
            chk("read", e[i], rxq[3 + i]);
        end
    endtask
    task automatic t_reset();
        chk("wip", 8'h00, {7'h00, wip});
        chk("wel", 8'h00, {7'h00, wel});
        chk("standby", 8'h01, {7'h00, standby});
        chk("sleep", 8'h00, {7'h00, sleep});
        chk("oe_n", 8'h01, {7'h00, so_oe_n});
        $display("t_reset done");
    endtask
    task automatic t_latch();
        cmd(`SED_OP_SET_LATCH);
        chk("wel", 8'h01, {7'h00, wel});
        status(8'h02);
        cmd(`SED_OP_CLR_LATCH);
        chk("wel", 8'h00, {7'h00, wel});
        $display("t_latch done");
    endtask
    task automatic t_guard();
        txq = '{`SED_OP_SET_LATCH, 8'h00};
        frame(1);
        chk("wel", 8'h00, {7'h00, wel});
        txq = '{`SED_OP_WRITE, 8'h00, 8'h10, 8'h55};
        frame(8);
        chk("wip", 8'h00, {7'h00, wip});
        cmd(`SED_OP_SET_LATCH);
        txq = '{`SED_OP_WRITE, 8'h00, 8'h10, 8'h55};
        frame(4);
        chk("wip", 8'h00, {7'h00, wip});
        chk("wel", 8'h01, {7'h00, wel});
        cmd(`SED_OP_CLR_LATCH);
        $display("t_guard done");
    endtask
    task automatic t_array();
        cmd(`SED_OP_SET_LATCH);
        cmd(`SED_OP_CHIP_ERASE);
        status(8'h03);
        wait_for(0, 1'b0, 70000);
        chk("wel", 8'h00, {7'h00, wel});
        wr(16'h0000, '{8'h5e});
        wr(16'h12fe, '{8'ha1, 8'hb2, 8'hc3});
        rd(16'hffff, '{8'hff, 8'h5e});
        pause_on = 1'b1;
        rd(16'h12fe, '{8'ha1, 8'hb2});
        pause_on = 1'b0;
        rd(16'h1200, '{8'hc3});
        $display("t_array done");
    endtask
    task automatic t_erase();
        erase(`SED_OP_PAGE_ERASE, 16'h12fe);
        rd(16'h1200, '{8'hff});
        rd(16'h0000, '{8'h5e});
        erase(`SED_OP_SECTOR_ERASE, 16'h0000);
        rd(16'h0000, '{8'hff});
        $display("t_erase done");
    endtask
    task automatic t_power();
        wait_for(1, 1'b1, 2700);
        chk("standby", 8'h01, {7'h00, standby});
        cmd(`SED_OP_SET_LATCH);
        cmd(`SED_OP_SLEEP);
        wait_for(2, 1'b1, 2700);
        chk("sleep", 8'h01, {7'h00, sleep});
        cmd(`SED_OP_CLR_LATCH);
        chk("wel", 8'h01, {7'h00, wel});
        txq = '{`SED_OP_SIG_WAKE, 8'h00, 8'h00, 8'h00, 8'h00};
        frame(8);
        chk("signature", 8'h3c, rxq[4]);
        chk("sleep", 8'h00, {7'h00, sleep});
        $display("t_power done");
    endtask
    task automatic t_status();
        cmd(`SED_OP_SET_LATCH);
        txq = '{`SED_OP_STAT_WR, 8'hff};
        frame(8);
        wait_for(0, 1'b0, 1000);
        status(8'h8c);
        $display("t_status done");
    endtask
    initial begin
        repeat (3) @(posedge clock_in);
        rstn_in <= 1'b1;
        @(posedge clock_in);
        t_reset();
        t_latch();
        t_guard();
        t_array();
        t_erase();
        t_power();
        t_status();
        test_done();
    end
endmodule

/* rtl/sed_cfg.svh */
`ifndef SED_CFG_SVH
`define SED_CFG_SVH

`define SED_CLK_NS 40

`define SED_OP_WRITE 8'h02
`define SED_OP_READ 8'h03
`define SED_OP_CLR_LATCH 8'h04
`define SED_OP_STAT_RD 8'h05
`define SED_OP_SET_LATCH 8'h06
`define SED_OP_STAT_WR 8'h01
`define SED_OP_PAGE_ERASE 8'h42
`define SED_OP_SECTOR_ERASE 8'hd8
`define SED_OP_CHIP_ERASE 8'hc7
`define SED_OP_SIG_WAKE 8'hab
`define SED_OP_SLEEP 8'hb9

`define SED_ADDR_W 16
`define SED_ARRAY_BYTES 65536
`define SED_PAGE_AW 8
`define SED_SECTOR_BYTES 16384
`define SED_ERASED 8'hff

`define SED_TWC_L_MS 6
`define SED_TWC_S_MS 5
`define SED_TSE_MS 15
`define SED_TCE_MS 15
`define SED_STANDBY_ENTRY_DELAY_US 100
`define SED_TPD_US 100

`define SED_TWC_L_CYC ((`SED_TWC_L_MS * 1000000) / `SED_CLK_NS)
`define SED_TWC_S_CYC ((`SED_TWC_S_MS * 1000000) / `SED_CLK_NS)
`define SED_TSE_CYC ((`SED_TSE_MS * 1000000) / `SED_CLK_NS)
`define SED_TCE_CYC ((`SED_TCE_MS * 1000000) / `SED_CLK_NS)
`define SED_STANDBY_ENTRY_DELAY_CYC ((`SED_STANDBY_ENTRY_DELAY_US * 1000) / `SED_CLK_NS)
`define SED_TPD_CYC ((`SED_TPD_US * 1000) / `SED_CLK_NS)

`endif

/* rtl/sed_mem.sv */
`timescale 1ns/1ns
module sed_mem #(
    parameter int AW = 8
) (
    input wire logic wr_clk_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_clk_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [7:0] rd_data_out
);
    logic [7:0] mem_ff [0:(1<<AW)-1];

    always_ff @(posedge wr_clk_in) begin
        if (wr_en_in) begin
            mem_ff[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge rd_clk_in) begin
        rd_data_out <= mem_ff[rd_addr_in];
    end
endmodule

/* rtl/sed_pkg.sv */
package sed_pkg;
    typedef enum logic [1:0] {
        C_IDLE,
        C_PROG
    } sed_core_type;

    typedef enum logic [1:0] {
        P_ACTIVE,
        P_STANDBY,
        P_SLEEP_PEND,
        P_SLEEP
    } sed_pwr_type;
endpackage

/* rtl/sed_sync.sv */
`timescale 1ns/1ns
module sed_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk_in) begin
        meta_ff <= d_in;
        q_out <= meta_ff;
    end
endmodule

/* rtl/sed_top.sv */
// Function
// - each command is captured into an eight-bit instruction register first
// - serial input is sampled on each rising serial clock edge
// - instruction, address and data travel most significant bit first
// - first bit is taken on first rising edge after select falls
// - pause freezes progress; resumes at the same bit position
// - code 03 reads the array from the following address
// - code 02 writes the array from the following address
// - code 06 sets the write-permission latch
// - code 04 clears the write-permission latch
// - code 42 erases one page within 6 ms
// - code d8 erases one sector within 15 ms
// - code c7 erases the whole array within 15 ms
// - code ab leaves deep power-down and shifts out the signature
// - code b9 enters deep power-down within 100 us of select rising
// - write or erase needs the latch set; latch clears on completion
// - read pointer advances per byte and wraps to zero at the top
// - write data past a page end wraps to the page start
`timescale 1ns/1ns
`include "sed_cfg.svh"
module sed_top import sed_pkg::*; #(
    parameter bit LARGE_DENSITY = 1'b1,
    parameter int TWC_L_CYC = `SED_TWC_L_CYC,
    parameter int TWC_S_CYC = `SED_TWC_S_CYC,
    parameter int TSE_CYC = `SED_TSE_CYC,
    parameter int TCE_CYC = `SED_TCE_CYC,
    // signature value is arbitrary
    parameter logic [7:0] SIG_BYTE = 8'h5a
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic hold_n_in,
    output logic so_out,
    output logic so_oe_n_out,
    output logic wip_out,
    output logic wel_out,
    output logic standby_out,
    output logic sleep_out
);
    localparam int TWC_CYC = LARGE_DENSITY ? TWC_L_CYC : TWC_S_CYC;
    localparam int AW = `SED_ADDR_W;
    localparam int PW = `SED_PAGE_AW;

    // link side: shift position, reset by select high
    logic [1:0] ph_ff;
    logic [2:0] bit_ff;
    logic [7:0] sr_ff;
    logic [7:0] cmd_ff;
    logic [7:0] ahi_ff;
    logic [AW-1:0] addr_ff;
    logic [AW-1:0] rptr_ff;
    logic [PW-1:0] woff_ff;
    logic [PW:0] wcnt_ff;
    logic seq_ff;
    logic end_al_ff;
    logic [1:0] end_ph_ff;
    logic [6:0] osr_ff;
    logic [7:0] byte_in;
    logic [AW-1:0] mem_raddr;
    logic [7:0] mem_rdata;
    logic pb_we;
    logic [4:0] stat_s;
    logic drv;

    // core side
    logic cs_n_s;
    logic cs_prev_ff;
    logic seen_ff;
    logic evt;
    sed_core_type st_ff;
    logic wip_ff;
    logic wel_ff;
    logic wpen_ff;
    logic [1:0] bp_ff;
    logic [18:0] tmr_ff;
    logic [16:0] left_ff;
    logic [AW-1:0] idx_ff;
    logic [AW-1:0] base_ff;
    logic fill_ff;
    logic wv_ff;
    logic [AW-1:0] wa_ff;
    logic [7:0] pb_rdata;
    logic [PW-1:0] pb_raddr;
    logic ok8;
    logic ok16;
    logic ok24;
    logic okw;
    sed_pwr_type pwr_ff;
    sed_pwr_type nxt_pwr;
    logic [11:0] pdly_ff;
    logic go_sleep;
    logic wake;

    assign byte_in = {sr_ff[6:0], si_in};

    // select high clears the bit position, so the next edge is bit 0
    always_ff @(posedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            ph_ff <= 2'h0;
            bit_ff <= 3'h0;
        end else if (hold_n_in) begin
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == 3'h7 && ph_ff != 2'h3) begin
                ph_ff <= ph_ff + 2'h1;
            end
        end
    end

    // frame results survive select high so the core can pick them up
    always_ff @(posedge sck_in) begin
        if (hold_n_in && !cs_n_in) begin
            sr_ff <= byte_in;
            end_al_ff <= (bit_ff == 3'h7);
            end_ph_ff <= ph_ff;
            if (ph_ff == 2'h0 && bit_ff == 3'h0) begin
                seq_ff <= ~seen_ff;
                wcnt_ff <= '0;
            end
            if (bit_ff == 3'h7) begin
                case (ph_ff)
                    2'h0: cmd_ff <= byte_in;
                    2'h1: ahi_ff <= byte_in;
                    2'h2: begin
                        addr_ff <= {ahi_ff, byte_in};
                        woff_ff <= byte_in[PW-1:0];
                        rptr_ff <= {ahi_ff, byte_in} + 16'h0001;
                    end
                    default: begin
                        rptr_ff <= rptr_ff + 16'h0001;
                        woff_ff <= woff_ff + 8'h01;
                        if (!wcnt_ff[PW]) begin
                            wcnt_ff <= wcnt_ff + 9'h001;
                        end
                    end
                endcase
            end
        end
    end

    // array read address, first byte fetched as the address completes
    assign mem_raddr = (ph_ff == 2'h2 && bit_ff == 3'h7) ? {ahi_ff, byte_in} : rptr_ff;
    // data bytes gather in the page buffer
    assign pb_we = hold_n_in && !cs_n_in && cmd_ff == `SED_OP_WRITE
                   && ph_ff == 2'h3 && bit_ff == 3'h7;

    sed_sync #(.W(5)) u_stat_sync (
        .clk_in(sck_in),
        .d_in({wpen_ff, bp_ff, wel_ff, wip_ff}),
        .q_out(stat_s)
    );

    always_comb begin
        drv = 1'b0;
        case (cmd_ff)
            `SED_OP_READ: drv = (ph_ff == 2'h3);
            `SED_OP_STAT_RD: drv = (ph_ff != 2'h0);
            `SED_OP_SIG_WAKE: drv = (ph_ff == 2'h3);
            default: drv = 1'b0;
        endcase
    end

    // output changes on the falling edge so the host samples it stable
    always_ff @(negedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            so_out <= 1'b0;
            osr_ff <= 7'h00;
            so_oe_n_out <= 1'b1;
        end else if (!hold_n_in) begin
            so_oe_n_out <= 1'b1;
        end else begin
            so_oe_n_out <= !drv;
            if (bit_ff == 3'h0) begin
                case (cmd_ff)
                    `SED_OP_READ: {so_out, osr_ff} <= mem_rdata;
                    `SED_OP_STAT_RD: {so_out, osr_ff} <= {stat_s[4], 3'h0, stat_s[3:0]};
                    default: {so_out, osr_ff} <= SIG_BYTE;
                endcase
            end else begin
                {so_out, osr_ff} <= {osr_ff, 1'b0};
            end
        end
    end

    sed_mem #(.AW(AW)) u_array (
        .wr_clk_in(clock_in),
        .wr_en_in(wv_ff),
        .wr_addr_in(wa_ff),
        .wr_data_in(fill_ff ? `SED_ERASED : pb_rdata),
        .rd_clk_in(sck_in),
        .rd_addr_in(mem_raddr),
        .rd_data_out(mem_rdata)
    );

    sed_mem #(.AW(PW)) u_page_buf (
        .wr_clk_in(sck_in),
        .wr_en_in(pb_we),
        .wr_addr_in(woff_ff),
        .wr_data_in(byte_in),
        .rd_clk_in(clock_in),
        .rd_addr_in(pb_raddr),
        .rd_data_out(pb_rdata)
    );

    sed_sync #(.W(1)) u_cs_sync (
        .clk_in(clock_in),
        .d_in(cs_n_in),
        .q_out(cs_n_s)
    );

    // link results are static while select is high, read after its sync
    assign evt = cs_n_s && !cs_prev_ff && (seq_ff != seen_ff);
    assign ok8 = end_al_ff && end_ph_ff == 2'h0;
    assign ok16 = end_al_ff && end_ph_ff == 2'h1;
    assign ok24 = end_al_ff && end_ph_ff == 2'h2;
    // write only when select rose right after a full data byte
    assign okw = end_al_ff && end_ph_ff == 2'h3 && wcnt_ff != '0;
    assign pb_raddr = base_ff[PW-1:0] + idx_ff[PW-1:0];

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            cs_prev_ff <= 1'b1;
            seen_ff <= 1'b0;
        end else begin
            cs_prev_ff <= cs_n_s;
            if (evt) begin
                seen_ff <= seq_ff;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            st_ff <= C_IDLE;
            wip_ff <= 1'b0;
            wel_ff <= 1'b0;
            wpen_ff <= 1'b0;
            bp_ff <= 2'h0;
            tmr_ff <= '0;
            left_ff <= '0;
            idx_ff <= '0;
            base_ff <= '0;
            fill_ff <= 1'b0;
            wv_ff <= 1'b0;
            wa_ff <= '0;
        end else begin
            wv_ff <= 1'b0;
            case (st_ff)
                C_IDLE: begin
                    idx_ff <= '0;
                    if (evt && pwr_ff != P_SLEEP && pwr_ff != P_SLEEP_PEND) begin
                        // set latch on an exact instruction
                        if (cmd_ff == `SED_OP_SET_LATCH && ok8) begin
                            wel_ff <= 1'b1;
                        end
                        if (cmd_ff == `SED_OP_CLR_LATCH && ok8) begin
                            wel_ff <= 1'b0;
                        end
                        // any array or status change needs the latch
                        if (wel_ff) begin
                            fill_ff <= 1'b1;
                            base_ff <= addr_ff;
                            case (cmd_ff)
                                `SED_OP_WRITE: if (okw) begin
                                    st_ff <= C_PROG;
                                    fill_ff <= 1'b0;
                                    left_ff <= {8'h00, wcnt_ff};
                                    tmr_ff <= 19'(TWC_CYC - 1);
                                end
                                // status write takes a write cycle
                                `SED_OP_STAT_WR: if (ok16) begin
                                    st_ff <= C_PROG;
                                    left_ff <= '0;
                                    wpen_ff <= ahi_ff[7];
                                    bp_ff <= ahi_ff[3:2];
                                    tmr_ff <= 19'(TWC_CYC - 1);
                                end
                                `SED_OP_PAGE_ERASE: if (ok24 && LARGE_DENSITY) begin
                                    st_ff <= C_PROG;
                                    base_ff <= {addr_ff[AW-1:PW], 8'h00};
                                    left_ff <= 17'(1 << PW);
                                    tmr_ff <= 19'(TWC_L_CYC - 1);
                                end
                                `SED_OP_SECTOR_ERASE: if (ok24 && LARGE_DENSITY) begin
                                    st_ff <= C_PROG;
                                    base_ff <= {addr_ff[AW-1:14], 14'h0000};
                                    left_ff <= 17'(`SED_SECTOR_BYTES);
                                    tmr_ff <= 19'(TSE_CYC - 1);
                                end
                                `SED_OP_CHIP_ERASE: if (ok8 && LARGE_DENSITY) begin
                                    st_ff <= C_PROG;
                                    base_ff <= '0;
                                    left_ff <= 17'(`SED_ARRAY_BYTES);
                                    tmr_ff <= 19'(TCE_CYC - 1);
                                end
                                default: fill_ff <= 1'b0;
                            endcase
                            if ((cmd_ff == `SED_OP_WRITE && okw)
                                || (cmd_ff == `SED_OP_STAT_WR && ok16)
                                || (LARGE_DENSITY && ((cmd_ff == `SED_OP_PAGE_ERASE && ok24)
                                || (cmd_ff == `SED_OP_SECTOR_ERASE && ok24)
                                || (cmd_ff == `SED_OP_CHIP_ERASE && ok8)))) begin
                                wip_ff <= 1'b1;
                            end
                        end
                    end
                end
                C_PROG: begin
                    // one byte per cycle; buffer read data arrives with wv_ff
                    if (left_ff != '0) begin
                        left_ff <= left_ff - 17'h00001;
                        idx_ff <= idx_ff + 16'h0001;
                        wv_ff <= 1'b1;
                        // page write wraps inside its page
                        wa_ff <= fill_ff ? base_ff + idx_ff : {base_ff[AW-1:PW], pb_raddr};
                    end
                    if (tmr_ff != '0) begin
                        tmr_ff <= tmr_ff - 19'h00001;
                    end else if (left_ff == '0 && !wv_ff) begin
                        st_ff <= C_IDLE;
                        wip_ff <= 1'b0;
                        // latch clears when the cycle completes
                        wel_ff <= 1'b0;
                    end
                end
                default: st_ff <= C_IDLE;
            endcase
        end
    end

    // sleep request accepted only on an exact instruction, when idle
    assign go_sleep = evt && ok8 && cmd_ff == `SED_OP_SLEEP && LARGE_DENSITY
                      && st_ff == C_IDLE;
    assign wake = evt && cmd_ff == `SED_OP_SIG_WAKE && LARGE_DENSITY;

    always_comb begin
        nxt_pwr = pwr_ff;
        case (pwr_ff)
            P_ACTIVE: begin
                if (go_sleep) begin
                    nxt_pwr = P_SLEEP_PEND;
                end else if (cs_n_s && pdly_ff == 12'(`SED_STANDBY_ENTRY_DELAY_CYC - 1)) begin
                    nxt_pwr = P_STANDBY;
                end
            end
            P_STANDBY: if (!cs_n_s) nxt_pwr = P_ACTIVE;
            // sleep entered after the power-down delay
            P_SLEEP_PEND: if (pdly_ff == 12'(`SED_TPD_CYC - 1)) nxt_pwr = P_SLEEP;
            P_SLEEP: if (wake) nxt_pwr = P_ACTIVE;
            default: nxt_pwr = P_ACTIVE;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            pwr_ff <= P_STANDBY;
            pdly_ff <= '0;
            standby_out <= 1'b1;
            sleep_out <= 1'b0;
        end else begin
            pwr_ff <= nxt_pwr;
            standby_out <= (nxt_pwr == P_STANDBY);
            sleep_out <= (nxt_pwr == P_SLEEP);
            if (nxt_pwr != pwr_ff || !cs_n_s) begin
                pdly_ff <= '0;
            end else if (pwr_ff == P_ACTIVE || pwr_ff == P_SLEEP_PEND) begin
                pdly_ff <= pdly_ff + 12'h001;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            wip_out <= 1'b0;
            wel_out <= 1'b0;
        end else begin
            wip_out <= wip_ff;
            wel_out <= wel_ff;
        end
    end
endmodule
